// [src/uwbg_uart.sv]
module uwbg_uart import uwbg_pkg::*; (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic rx_i,
  output logic tx_o,
  output logic irq_o
);
  // ==========================================================
  // software registers
  uwbg_fmt_t fmt;
  logic [7:0] fmt_reg, fmt_next, bgc_reg, bgc_next;
  logic [7:0] rll_reg, rll_next, rlh_reg, rlh_next;
  logic ren_reg, ren_next, tbx_reg, tbx_next;
  logic ti_reg, ti_next, ri_reg, ri_next;
  logic ovr_reg, ovr_next, perr_reg, perr_next;
  logic [7:0] rdata_reg, rdata_next;
  logic wr_cs, baud_en;
  logic [15:0] reload;
  // transmit side
  uwbg_st_t tx_st_reg, tx_st_next;
  logic [7:0] thr_reg, thr_next, tx_sh_reg, tx_sh_next;
  logic thre_reg, thre_next, tx_reg, tx_next, txx_reg, txx_next;
  logic [2:0] tx_bit_reg, tx_bit_next;
  logic [1:0] tx_half_reg, tx_half_next, tx_lim;
  logic tx_load, tx_ovf, tx_adv, ti_set;
  // receive side
  uwbg_st_t rx_st_reg, rx_st_next;
  logic rx_s1_reg, rx_s2_reg, rx_prev_reg;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [2:0] rx_bit_reg, rx_bit_next;
  logic rx_half_reg, rx_half_next, rxx_reg, rxx_next;
  logic rx_restart, rx_ovf, rx_samp, rx_done;
  logic push, ovr_set, ri_set, perr_set, pop;
  uwbg_rx_ent_t rx_ent, head;
  uwbg_rx_ent_t fifo_mem [0:2];
  logic [1:0] wp_reg, wp_next, rp_reg, rp_next, cnt_reg, cnt_next;
  logic [2:0] last_bit;

  assign fmt = uwbg_fmt_t'(fmt_reg);
  assign baud_en = bgc_reg[BGC_EN];
  assign reload = {rlh_reg, rll_reg};
  assign last_bit = 3'h4 + {1'b0, fmt.len};
  assign wr_cs = wr_i && addr_i == ADDR_CSR;

  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [1:0] len,
                                   input logic [1:0] pt);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - len);
    case (pt)
      PT_ODD: par_bit = ~^(d & m);
      PT_EVEN: par_bit = ^(d & m);
      PT_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // baud timers: one per direction so each can phase-align
  uwbg_baud_timer u_tx_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .en_i(baud_en),
    .restart_i(tx_load),
    .presc_sel_i(bgc_reg[1:0]),
    .reload_i(reload),
    .ovf_o(tx_ovf)
  );
  uwbg_baud_timer u_rx_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .en_i(baud_en),
    .restart_i(rx_restart),
    .presc_sel_i(bgc_reg[1:0]),
    .reload_i(reload),
    .ovf_o(rx_ovf)
  );

  // ==========================================================
  // transmitter; each overflow is half a bit time
  always_comb begin
    tx_st_next = tx_st_reg;
    thr_next = thr_reg;
    thre_next = thre_reg;
    tx_sh_next = tx_sh_reg;
    tx_next = tx_reg;
    txx_next = txx_reg;
    tx_bit_next = tx_bit_reg;
    tx_half_next = tx_half_reg;
    tx_load = 1'b0;
    ti_set = 1'b0;
    if (tx_st_reg == ST_STOP && fmt.stop_long) begin
      tx_lim = (fmt.len == 2'h0) ? 2'h2 : 2'h3;
    end else begin
      tx_lim = 2'h1;
    end
    tx_adv = tx_ovf && tx_half_reg == tx_lim;
    if (tx_ovf) begin
      tx_half_next = tx_adv ? 2'h0 : tx_half_reg + 2'h1;
    end
    if (wr_i && addr_i == ADDR_DATA) begin
      thr_next = wdata_i;
      thre_next = 1'b0;
    end
    case (tx_st_reg)
      ST_IDLE: begin
        tx_next = 1'b1;
        if (baud_en && !thre_reg) begin
          tx_load = 1'b1;
          tx_sh_next = thr_reg;
          thre_next = 1'b0;
          if (!(wr_i && addr_i == ADDR_DATA)) begin
            thre_next = 1'b1;
          end
          // parity wins the slot after the data
          txx_next = fmt.pe ? par_bit(thr_reg, fmt.len, fmt.ptype)
                            : tbx_reg;
          tx_bit_next = 3'h0;
          tx_half_next = 2'h0;
          tx_next = 1'b0;
          tx_st_next = ST_START;
        end
      end
      ST_START: if (tx_adv) begin
        tx_next = tx_sh_reg[0];
        tx_st_next = ST_DATA;
      end
      ST_DATA: if (tx_adv) begin
        if (tx_bit_reg == last_bit) begin
          if (fmt.pe || fmt.xbe) begin
            tx_next = txx_reg;
            tx_st_next = ST_EXTRA;
          end else begin
            tx_next = 1'b1;
            ti_set = 1'b1;
            tx_st_next = ST_STOP;
          end
        end else begin
          tx_sh_next = {1'b0, tx_sh_reg[7:1]};
          tx_next = tx_sh_reg[1];
          tx_bit_next = tx_bit_reg + 3'h1;
        end
      end
      ST_EXTRA: if (tx_adv) begin
        tx_next = 1'b1;
        ti_set = 1'b1;
        tx_st_next = ST_STOP;
      end
      ST_STOP: if (tx_adv) begin
        tx_st_next = ST_IDLE;
      end
      default: tx_st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st_reg <= ST_IDLE;
      thr_reg <= 8'h00;
      thre_reg <= 1'b1;
      tx_sh_reg <= 8'h00;
      tx_reg <= 1'b1;
      txx_reg <= 1'b0;
      tx_bit_reg <= 3'h0;
      tx_half_reg <= 2'h0;
    end else begin
      tx_st_reg <= tx_st_next;
      thr_reg <= thr_next;
      thre_reg <= thre_next;
      tx_sh_reg <= tx_sh_next;
      tx_reg <= tx_next;
      txx_reg <= txx_next;
      tx_bit_reg <= tx_bit_next;
      tx_half_reg <= tx_half_next;
    end
  end

  // ==========================================================
  // receiver; samples land mid-bit since the timer restarts on edge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rx_i;
      rx_s2_reg <= rx_s1_reg;
      rx_prev_reg <= rx_s2_reg;
    end
  end

  assign rx_restart = rx_st_reg == ST_IDLE && rx_prev_reg && !rx_s2_reg
                      && ren_reg && baud_en;
  assign rx_samp = rx_ovf && rx_half_reg;

  always_comb begin
    rx_st_next = rx_st_reg;
    rx_sh_next = rx_sh_reg;
    rx_bit_next = rx_bit_reg;
    rx_half_next = rx_ovf ? !rx_half_reg : rx_half_reg;
    rxx_next = rxx_reg;
    rx_done = 1'b0;
    case (rx_st_reg)
      ST_IDLE: if (rx_restart) begin
        rx_half_next = 1'b0;
        rx_st_next = ST_START;
      end
      ST_START: if (rx_ovf) begin
        rx_half_next = 1'b0;
        rx_bit_next = 3'h0;
        rx_st_next = rx_s2_reg ? ST_IDLE : ST_DATA; // glitch filter
      end
      ST_DATA: if (rx_samp) begin
        rx_sh_next = {rx_s2_reg, rx_sh_reg[7:1]};
        rx_bit_next = rx_bit_reg + 3'h1;
        if (rx_bit_reg == last_bit) begin
          rx_st_next = (fmt.pe || fmt.xbe) ? ST_EXTRA : ST_STOP;
        end
      end
      ST_EXTRA: if (rx_samp) begin
        rxx_next = rx_s2_reg;
        rx_st_next = ST_STOP;
      end
      ST_STOP: if (rx_samp) begin
        rx_done = 1'b1;
        rx_st_next = ST_IDLE;
      end
      default: rx_st_next = ST_IDLE;
    endcase
    rx_ent.data = rx_sh_reg >> (2'h3 - fmt.len);
    rx_ent.xbit = (fmt.xbe && !fmt.pe) ? rxx_reg : rx_s2_reg;
    push = rx_done && rx_s2_reg && cnt_reg != FIFO_DEPTH;
    ovr_set = rx_done && rx_s2_reg && cnt_reg == FIFO_DEPTH;
    ri_set = push && (!fmt.mce || rx_ent.xbit);
    perr_set = rx_done && fmt.pe
      && rxx_reg != par_bit(rx_ent.data, fmt.len, fmt.ptype);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st_reg <= ST_IDLE;
      rx_sh_reg <= 8'h00;
      rx_bit_reg <= 3'h0;
      rx_half_reg <= 1'b0;
      rxx_reg <= 1'b0;
    end else begin
      rx_st_reg <= rx_st_next;
      rx_sh_reg <= rx_sh_next;
      rx_bit_reg <= rx_bit_next;
      rx_half_reg <= rx_half_next;
      rxx_reg <= rxx_next;
    end
  end

  // ==========================================================
  // receive FIFO
  assign head = fifo_mem[rp_reg];
  assign pop = rd_i && addr_i == ADDR_DATA && cnt_reg != 2'h0;

  always_comb begin
    wp_next = wp_reg;
    rp_next = rp_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wp_next = (wp_reg == 2'h2) ? 2'h0 : wp_reg + 2'h1;
    end
    if (pop) begin
      rp_next = (rp_reg == 2'h2) ? 2'h0 : rp_reg + 2'h1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push) begin
      fifo_mem[wp_reg] <= rx_ent;
    end
  end

  // ==========================================================
  // register file and flags; hardware set beats software clear
  always_comb begin
    fmt_next = fmt_reg;
    bgc_next = bgc_reg;
    rll_next = rll_reg;
    rlh_next = rlh_reg;
    ren_next = ren_reg;
    tbx_next = tbx_reg;
    ti_next = ti_reg;
    ri_next = ri_reg;
    ovr_next = ovr_reg;
    perr_next = perr_reg;
    if (wr_i) begin
      case (addr_i)
        ADDR_CSR: begin
          ren_next = wdata_i[CS_REN];
          tbx_next = wdata_i[CS_TBX];
          ti_next = wdata_i[CS_TI];
          ovr_next = wdata_i[CS_OVR];
          perr_next = wdata_i[CS_PERR];
          // clearing is refused while more than one byte waits
          if (cnt_reg < 2'h2) begin
            ri_next = wdata_i[CS_RI];
          end
        end
        ADDR_FMT: fmt_next = wdata_i;
        ADDR_BGC: bgc_next = wdata_i;
        ADDR_RLL: rll_next = wdata_i;
        ADDR_RLH: rlh_next = wdata_i;
        default: fmt_next = fmt_reg;
      endcase
    end
    ti_next = ti_next | ti_set;
    ri_next = ri_next | ri_set;
    ovr_next = ovr_next | ovr_set;
    perr_next = perr_next | perr_set;
    rdata_next = 8'h00;
    if (rd_i) begin
      case (addr_i)
        // empty queue shows 0, never a stale or unwritten entry
        ADDR_CSR: rdata_next = {ovr_reg, perr_reg, thre_reg, ren_reg,
                                tbx_reg, head.xbit & (cnt_reg != 2'h0),
                                ti_reg, ri_reg};
        ADDR_FMT: rdata_next = fmt_reg;
        ADDR_DATA: rdata_next = pop ? head.data : 8'h00;
        ADDR_BGC: rdata_next = bgc_reg;
        ADDR_RLL: rdata_next = rll_reg;
        ADDR_RLH: rdata_next = rlh_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fmt_reg <= FMT_RESET;
      bgc_reg <= BGC_RESET;
      rll_reg <= RL_RESET;
      rlh_reg <= RL_RESET;
      ren_reg <= 1'b0;
      tbx_reg <= 1'b0;
      ti_reg <= 1'b0;
      ri_reg <= 1'b0;
      ovr_reg <= 1'b0;
      perr_reg <= 1'b0;
      rdata_reg <= 8'h00;
      wp_reg <= 2'h0;
      rp_reg <= 2'h0;
      cnt_reg <= 2'h0;
    end else begin
      fmt_reg <= fmt_next;
      bgc_reg <= bgc_next;
      rll_reg <= rll_next;
      rlh_reg <= rlh_next;
      ren_reg <= ren_next;
      tbx_reg <= tbx_next;
      ti_reg <= ti_next;
      ri_reg <= ri_next;
      ovr_reg <= ovr_next;
      perr_reg <= perr_next;
      rdata_reg <= rdata_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign tx_o = tx_reg;
  assign irq_o = bgc_reg[BGC_IE] && (ti_reg || ri_reg);

  // ==========================================================
  // checks
  chk_irq_on_flag: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) bgc_reg[BGC_IE] && $rose(ti_reg) |-> irq_o)
    else $error("no interrupt on transmit flag");
  chk_flag_persists: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) ti_reg && !wr_cs |=> ti_reg)
    else $error("transmit flag cleared by hardware");
  chk_ri_clear_held: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) wr_cs && !wdata_i[CS_RI] && ri_reg
    && cnt_reg > 2'h1 |=> ri_reg) else $error("receive flag cleared");
  chk_fifo_bound: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) cnt_reg <= FIFO_DEPTH)
    else $error("fifo count above depth");
  chk_overrun_flag: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) rx_done && rx_s2_reg && cnt_reg == FIFO_DEPTH
    && !pop |=> ovr_reg && cnt_reg == FIFO_DEPTH)
    else $error("overrun missed");
  chk_ti_at_stop: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) tx_st_reg != ST_STOP ##1 tx_st_reg == ST_STOP
    |-> ti_reg && tx_o) else $error("stop entered without flag");
  chk_start_low: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) tx_st_reg == ST_START |-> !tx_o)
    else $error("start bit not low");
  chk_idle_high: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) tx_st_reg == ST_IDLE |-> tx_o)
    else $error("idle line not high");
  chk_read_head: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) pop |=> rdata_o == $past(head.data))
    else $error("data read not oldest byte");
endmodule

// [src/uwbg_pkg.sv]
package uwbg_pkg;
  // ==========================================================
  // register map
  localparam logic [2:0] ADDR_CSR = 3'h0;
  localparam logic [2:0] ADDR_FMT = 3'h1;
  localparam logic [2:0] ADDR_DATA = 3'h2;
  localparam logic [2:0] ADDR_BGC = 3'h3;
  localparam logic [2:0] ADDR_RLL = 3'h4;
  localparam logic [2:0] ADDR_RLH = 3'h5;
  // ==========================================================
  // serial_control_status fields
  localparam int CS_OVR = 7;
  localparam int CS_PERR = 6;
  localparam int CS_THRE = 5;
  localparam int CS_REN = 4;
  localparam int CS_TBX = 3;
  localparam int CS_RBX = 2;
  localparam int CS_TI = 1;
  localparam int CS_RI = 0;
  // ==========================================================
  // baud_gen_control fields
  localparam int BGC_IE = 7;
  localparam int BGC_EN = 6;
  localparam logic [1:0] PS_DIV12 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [1:0] PS_DIV48 = 2'h2;
  localparam logic [1:0] PS_DIV1 = 2'h3;
  localparam logic [5:0] PS_LAST12 = 6'h0B;
  localparam logic [5:0] PS_LAST4 = 6'h03;
  localparam logic [5:0] PS_LAST48 = 6'h2F;
  localparam logic [5:0] PS_LAST1 = 6'h00;
  localparam logic [15:0] TIMER_TOP = 16'hFFFF;
  // ==========================================================
  // reset values, sizes and parity types
  localparam logic [7:0] FMT_RESET = 8'h0C;
  localparam logic [7:0] BGC_RESET = 8'h00;
  localparam logic [7:0] RL_RESET = 8'h00;
  localparam logic [1:0] FIFO_DEPTH = 2'h3;
  localparam logic [1:0] PT_ODD = 2'h0;
  localparam logic [1:0] PT_EVEN = 2'h1;
  localparam logic [1:0] PT_MARK = 2'h2;
  localparam logic [1:0] PT_SPACE = 2'h3;
  // ==========================================================
  // types
  typedef struct packed {
    logic mce;
    logic [1:0] ptype;
    logic pe;
    logic [1:0] len;
    logic xbe;
    logic stop_long;
  } uwbg_fmt_t;
  typedef struct packed {
    logic xbit;
    logic [7:0] data;
  } uwbg_rx_ent_t;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_EXTRA,
    ST_STOP} uwbg_st_t;
endpackage

// [src/uwbg_baud_timer.sv]
module uwbg_baud_timer import uwbg_pkg::*; (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic restart_i,
  input wire logic [1:0] presc_sel_i,
  input wire logic [15:0] reload_i,
  output logic ovf_o
);
  logic [5:0] pre_reg, pre_next, pre_last;
  logic [15:0] cnt_reg, cnt_next;
  logic ovf_reg, ovf_next;

  // ==========================================================
  // prescaler and reloading up-counter
  always_comb begin
    case (presc_sel_i)
      PS_DIV12: pre_last = PS_LAST12;
      PS_DIV4: pre_last = PS_LAST4;
      PS_DIV48: pre_last = PS_LAST48;
      default: pre_last = PS_LAST1;
    endcase
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    ovf_next = 1'b0;
    // restart aligns the half-bit phase to a frame edge
    if (!en_i || restart_i) begin
      pre_next = 6'h00;
      cnt_next = reload_i;
    end else if (pre_reg == pre_last) begin
      pre_next = 6'h00;
      if (cnt_reg == TIMER_TOP) begin
        cnt_next = reload_i;
        ovf_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end else begin
      pre_next = pre_reg + 6'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_reg <= 6'h00;
      cnt_reg <= 16'h0000;
      ovf_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      ovf_reg <= ovf_next;
    end
  end

  assign ovf_o = ovf_reg;

  chk_reload_on_ovf: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) ovf_reg && $stable(reload_i)
    |-> cnt_reg == reload_i) else $error("timer not reloaded");
  chk_gen_disabled: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i) !en_i |=> !ovf_reg)
    else $error("tick while disabled");
endmodule

// [sim/uwbg_remote.sv]
// ==========================================================
// remote serial device facing the port
module uwbg_remote (
  input wire logic mclk_i,
  input wire logic line_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // clocks per bit; 16 keeps the rate at clock/16 at most
  int bitc = 16;
  initial line_o = 1'h1;
  task automatic send(input logic [7:0] d, input int n, input bit hx,
    input logic xb, input logic sb);
    @(posedge mclk_i);
    line_o <= 1'h0;
    repeat (bitc) @(posedge mclk_i);
    for (int i = 0; i < n; i++) begin
      line_o <= d[i];
      repeat (bitc) @(posedge mclk_i);
    end
    if (hx) begin
      line_o <= xb;
      repeat (bitc) @(posedge mclk_i);
    end
    line_o <= sb;
    repeat (bitc) @(posedge mclk_i);
    // line pulled back to idle high between frames
    line_o <= 1'h1;
    repeat (3 * bitc) @(posedge mclk_i);
  endtask
  task automatic cap(input int n, input bit hx, output logic [7:0] d,
    output logic xb, output logic sb, output bit ok);
    int w;
    d = 8'h00;
    xb = 1'h0;
    sb = 1'h0;
    ok = 1'b0;
    w = 0;
    while (line_i !== 1'h0 && w < 4000) begin
      @(posedge mclk_i);
      w++;
    end
    if (w >= 4000) return;
    // sample mid-bit, away from the edges
    repeat (bitc / 2) @(posedge mclk_i);
    for (int i = 0; i < n; i++) begin
      repeat (bitc) @(posedge mclk_i);
      d[i] = line_i;
    end
    if (hx) begin
      repeat (bitc) @(posedge mclk_i);
      xb = line_i;
    end
    repeat (bitc) @(posedge mclk_i);
    sb = line_i;
    ok = 1'b1;
  endtask
endmodule

// [sim/uwbg_uart_tb.sv]
module uwbg_uart_tb import uwbg_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic [7:0] rdata_o;
  logic rx_i;
  logic tx_o;
  logic irq_o;
  int fails = 0;
  int n_tests = 0;
  logic [7:0] v, d, dm;
  logic x, s, p;
  bit ok;
  int c;
  logic [1:0] ps [6] = '{PS_DIV1, PS_DIV1, PS_DIV1, PS_DIV4, PS_DIV12,
    PS_DIV48};
  logic [7:0] rl [6] = '{8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hFD, 8'hFE};
  logic [7:0] fm [6] = '{8'h0C, 8'h0D, 8'h01, 8'h0C, 8'h0C, 8'h0C};
  int ex [6] = '{160, 176, 120, 640, 720, 1920};

  always #5 mclk_i = ~mclk_i;

  uwbg_uart uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_i(rx_i), .tx_o(tx_o), .irq_o(irq_o));
  uwbg_remote far (.mclk_i(mclk_i), .line_i(tx_o), .line_o(rx_i));

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] dv);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= dv;
    wr_i <= 1'h1;
    @(posedge mclk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] dv);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge mclk_i);
    rd_i <= 1'h0;
    #1 dv = rdata_o;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] r;
    rd(a, r);
    check("register read", {8'h00, r}, {8'h00, exp});
  endtask
  task automatic tx_get(input int n, input bit hx);
    far.cap(n, hx, d, x, s, ok);
    if (!ok) begin
      fails++;
      report_and_stop();
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    check("idle tx", {15'h0, tx_o}, 16'h0001);
    rchk(ADDR_CSR, 8'h20);
    rchk(ADDR_BGC, BGC_RESET);
    rchk(ADDR_RLH, RL_RESET);
    rchk(3'h6, 8'h00);
    rchk(ADDR_DATA, 8'h00);
    wr(ADDR_RLH, 8'hFF);
    wr(ADDR_RLL, 8'hF8);
    wr(ADDR_BGC, 8'hC3);
    rchk(ADDR_RLL, 8'hF8);
    rchk(ADDR_BGC, 8'hC3);
    // plain frame, then flag and interrupt behaviour
    wr(ADDR_DATA, 8'hA5);
    tx_get(8, 1'b0);
    check("tx data", {8'h00, d}, 16'h00A5);
    check("tx stop", {15'h0, s}, 16'h0001);
    check("irq at stop", {15'h0, irq_o}, 16'h0001);
    rchk(ADDR_CSR, 8'h22);
    check("irq held", {15'h0, irq_o}, 16'h0001);
    wr(ADDR_CSR, 8'h08);
    repeat (2) @(posedge mclk_i);
    check("irq cleared", {15'h0, irq_o}, 16'h0000);
    // every length and parity type, extra bit requested too
    for (int l = 0; l < 4; l++) begin
      dm = 8'h5B & (8'hFF >> (3 - l));
      case (2'(l))
        PT_ODD: p = ~^dm;
        PT_EVEN: p = ^dm;
        PT_MARK: p = 1'h1;
        default: p = 1'h0;
      endcase
      wr(ADDR_FMT, {1'h0, 2'(l), 1'h1, 2'(l), 1'h1, 1'h0});
      wr(ADDR_DATA, 8'h5B);
      tx_get(5 + l, 1'b1);
      check("tx length", {8'h00, d}, {8'h00, dm});
      check("tx parity", {15'h0, x}, {15'h0, p});
      repeat (32) @(posedge mclk_i);
    end
    wr(ADDR_FMT, 8'h0E);
    wr(ADDR_DATA, 8'h3C);
    tx_get(8, 1'b1);
    check("tx extra", {15'h0, x}, 16'h0001);
    repeat (32) @(posedge mclk_i);
    // frame period for prescalers, reloads and stop lengths
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_RLL, rl[k]);
      wr(ADDR_BGC, {6'h30, ps[k]});
      wr(ADDR_FMT, fm[k]);
      wr(ADDR_DATA, 8'hFF);
      wr(ADDR_DATA, 8'hFF);
      c = 0;
      while (tx_o !== 1'h0 && c < 100) begin
        @(posedge mclk_i);
        c++;
      end
      c = 0;
      while (tx_o !== 1'h1 && c < 5000) begin
        @(posedge mclk_i);
        c++;
      end
      while (tx_o !== 1'h0 && c < 5000) begin
        @(posedge mclk_i);
        c++;
      end
      // start bit runs one clock longer, one idle clock before the next load
      check("frame", 16'(c), 16'(ex[k] + 2));
      repeat (ex[k] + 20) @(posedge mclk_i);
    end
    wr(ADDR_RLL, 8'hF8);
    wr(ADDR_BGC, 8'hC3);
    wr(ADDR_FMT, 8'h0C);
    wr(ADDR_CSR, 8'h10);
    // receive: bad stop, then overrun of the queue
    far.send(8'h11, 8, 1'b0, 1'h0, 1'h0);
    rd(ADDR_CSR, v);
    check("bad stop dropped", {15'h0, v[CS_RI]}, 16'h0000);
    for (int i = 0; i < 4; i++) far.send(8'h31 + 8'(i), 8, 1'b0, 1'h0, 1'h1);
    rchk(ADDR_CSR, 8'hB5);
    check("irq on receive", {15'h0, irq_o}, 16'h0001);
    wr(ADDR_CSR, 8'h10);
    rchk(ADDR_CSR, 8'h35);
    rchk(ADDR_DATA, 8'h31);
    wr(ADDR_CSR, 8'h10);
    rchk(ADDR_DATA, 8'h32);
    wr(ADDR_CSR, 8'h10);
    rchk(ADDR_CSR, 8'h34);
    rchk(ADDR_DATA, 8'h33);
    rchk(ADDR_DATA, 8'h00);
    // parity error and good parity
    wr(ADDR_FMT, 8'h3C);
    far.send(8'h03, 8, 1'b1, 1'h1, 1'h1);
    rchk(ADDR_CSR, 8'h75);
    wr(ADDR_CSR, 8'h10);
    rchk(ADDR_DATA, 8'h03);
    far.send(8'h07, 8, 1'b1, 1'h1, 1'h1);
    rchk(ADDR_CSR, 8'h35);
    wr(ADDR_CSR, 8'h10);
    rchk(ADDR_DATA, 8'h07);
    // multiprocessor: data frame silent, address frame flagged
    wr(ADDR_FMT, 8'h8E);
    far.send(8'h55, 8, 1'b1, 1'h0, 1'h1);
    rd(ADDR_CSR, v);
    check("data frame flag", {15'h0, v[CS_RI]}, 16'h0000);
    far.send(8'hA7, 8, 1'b1, 1'h1, 1'h1);
    rd(ADDR_CSR, v);
    check("addr frame flag", {15'h0, v[CS_RI]}, 16'h0001);
    check("data frame extra", {15'h0, v[CS_RBX]}, 16'h0000);
    rchk(ADDR_DATA, 8'h55);
    rd(ADDR_CSR, v);
    check("addr frame extra", {15'h0, v[CS_RBX]}, 16'h0001);
    // generator off: nothing leaves the port
    wr(ADDR_BGC, 8'h03);
    wr(ADDR_DATA, 8'h00);
    c = 0;
    repeat (200) begin
      @(posedge mclk_i);
      if (tx_o !== 1'h1) c++;
    end
    check("tx while off", 16'(c), 16'h0000);
    report_and_stop();
  end
endmodule
